// [afe_regs_cfg.svh]
// Register offsets, field positions, reset values and response codes
// Assumes inclusion by the register bank and its package users only
`ifndef AFE_REGS_CFG_SVH
`define AFE_REGS_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_FRONTEND_CTRL 12'h0C8
`define OFS_INTERCHIP_EN 12'h140
`define OFS_EVENT_STATUS 12'h200
`define OFS_EVENT_MASK 12'h204
`define ADDR_W 12

////////////////////////////////////////////////////////////////////////////
// Front-end control fields
`define BIT_TERM_EN 29
`define BIT_LINE_INVALID_N 28
`define BIT_DISCONNECT 27
`define SQU_HI 26
`define SQU_LO 24
`define CTRL_RW_MASK 32'h27000000

////////////////////////////////////////////////////////////////////////////
// Interchip enable fields
`define BIT_MODE_SEL 24
`define BIT_DRV_50 18
`define BIT_SLEW 17
`define BIT_SWAP 16
`define IC_RW_MASK 32'h01070000

////////////////////////////////////////////////////////////////////////////
// Event status bits and reset values
`define EV_DISCONNECT 0
`define EV_LINE_INVALID 1
`define EV_IMAGE_LOAD 2
`define EV_W 3
`define EV_RESET 3'h0
`define SQU_RESET 3'h0
`define BIT_RESET 1'h0
`define STRAP_SETTLE 2'h2

////////////////////////////////////////////////////////////////////////////
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [afe_regs_pkg.sv]
// Types shared by the front-end configuration register bank
// Assumes the constants header is compiled alongside
package afe_regs_pkg;

   // Configuration image fields loaded from EEPROM or OTP
   typedef struct packed {
      logic [2:0] squelch;
      logic drv_50;
      logic slew;
      logic swap;
   } cfg_image_t;

   // Analog front-end status inputs
   typedef struct packed {
      logic line_invalid_n;
      logic disconnect;
   } afe_status_t;

endpackage

// [sync_two_stage.sv]
// Two flip-flop synchroniser for asynchronous levels
// Assumes inputs are levels that hold for several clock periods
`timescale 1ns/1ns

module sync_two_stage #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   ////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stage_one <= '0;
         sync_out <= '0;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end

endmodule

// [usb_afe_interchip_config_regs.sv]
// Front-end and interchip configuration register bank, AXI4-Lite slave
// Assumes soft reset and image load pulses come from logic on mclk,
// while front-end status and the strap pin are asynchronous
// Contract
// - Bit 29 drives high-speed termination enable
// - Bit 28 reads active-low line invalid flag
// - Bit 27 disconnect, sampled at end-of-packet
// - Bits 26:24 drive squelch trip adjust
// - Retention guard keeps squelch over soft resets
// - Squelch default from EEPROM, OTP, else zero
// - Soft resets reload fields from loaded image
// - Bit 24 selects interchip or USB mode
// - Mode default follows interchip select strap
// - Bit 18 selects 50 ohm driver impedance
// - Bit 17 enables 30 percent slew adjust
// - Bit 16 exchanges data and strobe pins
// - Driver, slew, swap defaults from image source
`timescale 1ns/1ns
`include "afe_regs_cfg.svh"

module usb_afe_interchip_config_regs
   import afe_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic eeprom_present,
   input wire logic otp_programmed,
   input wire cfg_image_t eeprom_image,
   input wire cfg_image_t otp_image,
   input wire logic image_load,
   input wire logic usb_bus_reset,
   input wire logic lite_reset,
   input wire logic reset_retention_guard,
   input wire logic interchip_select_strap,
   input wire afe_status_t afe_status_async,
   input wire logic hs_eop_bit32,
   output logic hs_termination_enable,
   output logic [2:0] squelch_trip_adjust,
   output logic interchip_mode_select,
   output logic driver_50ohm_select,
   output logic strobe_slew_adjust,
   output logic data_strobe_exchange,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // Image source selection, EEPROM before OTP before zero
   function automatic cfg_image_t pick_image(input logic ee_ok,
                                             input logic otp_ok,
                                             input cfg_image_t ee,
                                             input cfg_image_t otp);
      cfg_image_t img;
      img = '0;
      if (ee_ok) begin
         img = ee;
      end else if (otp_ok) begin
         img = otp;
      end
      return img;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   afe_status_t afe_sync;
   logic strap_sync;
   logic [1:0] strap_cnt;
   cfg_image_t image;
   logic disc_flag;
   logic invalid_prev;
   logic [`EV_W-1:0] ev_status;
   logic [`EV_W-1:0] ev_mask;
   logic aw_held;
   logic w_held;
   logic [`ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for front-end status and the strap pin
   sync_two_stage #(.WIDTH(2)) u_afe_sync (
      .mclk(mclk),
      .resetn(resetn),
      .async_in(afe_status_async),
      .sync_out(afe_sync)
   );

   sync_two_stage #(.WIDTH(1)) u_strap_sync (
      .mclk(mclk),
      .resetn(resetn),
      .async_in(interchip_select_strap),
      .sync_out(strap_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire wr_do = aw_held && w_held && !s_axi_bvalid;
   wire rd_do = s_axi_arvalid && s_axi_arready;
   wire wr_ctrl = aw_addr == `OFS_FRONTEND_CTRL;
   wire wr_ic = aw_addr == `OFS_INTERCHIP_EN;
   wire wr_stat = aw_addr == `OFS_EVENT_STATUS;
   wire wr_mask = aw_addr == `OFS_EVENT_MASK;
   wire wr_hit = wr_ctrl | wr_ic | wr_stat | wr_mask;
   wire rd_ctrl = s_axi_araddr == `OFS_FRONTEND_CTRL;
   wire rd_ic = s_axi_araddr == `OFS_INTERCHIP_EN;
   wire rd_stat = s_axi_araddr == `OFS_EVENT_STATUS;
   wire rd_mask = s_axi_araddr == `OFS_EVENT_MASK;
   wire rd_hit = rd_ctrl | rd_ic | rd_stat | rd_mask;
   wire lane3 = wr_do && w_strb[3];
   wire lane2 = wr_do && w_strb[2];
   wire lane0 = wr_do && w_strb[0];
   wire soft_rst = usb_bus_reset | lite_reset;
   wire strap_take = strap_cnt == `STRAP_SETTLE;
   wire cfg_image_t loaded = pick_image(eeprom_present, otp_programmed,
                                        eeprom_image, otp_image);

   ////////////////////////////////////////////////////////////////////////
   // Read words, reserved bits zero
   wire [31:0] ctrl_word = {2'h0, hs_termination_enable,
                            afe_sync.line_invalid_n, disc_flag,
                            squelch_trip_adjust, 24'h0};
   wire [31:0] ic_word = {7'h0, interchip_mode_select, 5'h0,
                          driver_50ohm_select, strobe_slew_adjust,
                          data_strobe_exchange, 16'h0};
   wire [31:0] rd_word = rd_ctrl ? ctrl_word :
                         rd_ic ? ic_word :
                         rd_stat ? {29'h0, ev_status} :
                         rd_mask ? {29'h0, ev_mask} : 32'h0;

   ////////////////////////////////////////////////////////////////////////
   // Next values of configuration fields; soft reset beats a write
   wire [2:0] next_squelch = image_load ? loaded.squelch :
      (soft_rst && !reset_retention_guard) ? image.squelch :
      (soft_rst) ? squelch_trip_adjust :
      (lane3 && wr_ctrl) ? w_data[`SQU_HI:`SQU_LO] :
      squelch_trip_adjust;
   wire next_drv = image_load ? loaded.drv_50 :
      soft_rst ? image.drv_50 :
      (lane2 && wr_ic) ? w_data[`BIT_DRV_50] : driver_50ohm_select;
   wire next_slew = image_load ? loaded.slew :
      soft_rst ? image.slew :
      (lane2 && wr_ic) ? w_data[`BIT_SLEW] : strobe_slew_adjust;
   wire next_swap = image_load ? loaded.swap :
      soft_rst ? image.swap :
      (lane2 && wr_ic) ? w_data[`BIT_SWAP] : data_strobe_exchange;
   wire next_term = (lane3 && wr_ctrl) ? w_data[`BIT_TERM_EN] :
                    hs_termination_enable;
   wire next_mode = strap_take ? strap_sync :
      (lane3 && wr_ic) ? w_data[`BIT_MODE_SEL] : interchip_mode_select;
   wire next_disc = hs_eop_bit32 ? afe_sync.disconnect : disc_flag;

   ////////////////////////////////////////////////////////////////////////
   // Event status: set beats write-one-to-clear
   wire [`EV_W-1:0] ev_set = {image_load,
                              afe_sync.line_invalid_n && !invalid_prev,
                              hs_eop_bit32 && afe_sync.disconnect};
   wire [`EV_W-1:0] ev_clr = (lane0 && wr_stat) ? w_data[`EV_W-1:0] : '0;
   wire [`EV_W-1:0] next_status = (ev_status & ~ev_clr) | ev_set;

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         image <= '0;
         squelch_trip_adjust <= `SQU_RESET;
         driver_50ohm_select <= `BIT_RESET;
         strobe_slew_adjust <= `BIT_RESET;
         data_strobe_exchange <= `BIT_RESET;
      end else begin
         if (image_load) begin
            image <= loaded;
         end
         squelch_trip_adjust <= next_squelch;
         driver_50ohm_select <= next_drv;
         strobe_slew_adjust <= next_slew;
         data_strobe_exchange <= next_swap;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hs_termination_enable <= `BIT_RESET;
         interchip_mode_select <= `BIT_RESET;
         strap_cnt <= '0;
         disc_flag <= `BIT_RESET;
         invalid_prev <= `BIT_RESET;
      end else begin
         hs_termination_enable <= next_term;
         interchip_mode_select <= next_mode;
         strap_cnt <= (strap_cnt == 2'h3) ? strap_cnt : strap_cnt + 2'h1;
         disc_flag <= next_disc;
         invalid_prev <= afe_sync.line_invalid_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ev_status <= `EV_RESET;
         ev_mask <= `EV_RESET;
      end else begin
         ev_status <= next_status;
         if (lane0 && wr_mask) begin
            ev_mask <= w_data[`EV_W-1:0];
         end
      end
   end

   assign irq = |(ev_status & ev_mask);

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channels
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_do) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channels
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (rd_do) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   sequence s_ctrl_write;
      lane3 && wr_ctrl && !soft_rst && !image_load;
   endsequence

   property p_term_follows;
      lane3 && wr_ctrl |=> hs_termination_enable == $past(w_data[29]);
   endproperty
   a_term_follows: assert property (p_term_follows)
      else $error("termination enable did not follow write");

   property p_invalid_read;
      rd_do && rd_ctrl |=> s_axi_rdata[28] == $past(afe_sync[1]);
   endproperty
   a_invalid_read: assert property (p_invalid_read)
      else $error("line invalid flag read wrong");

   property p_disc_sample;
      hs_eop_bit32 |=> disc_flag == $past(afe_sync.disconnect)
         ##1 ($past(hs_eop_bit32) || $stable(disc_flag));
   endproperty
   a_disc_sample: assert property (p_disc_sample)
      else $error("disconnect flag not sampled at end of packet");

   property p_squelch_write;
      s_ctrl_write |=> squelch_trip_adjust == $past(w_data[26:24]);
   endproperty
   a_squelch_write: assert property (p_squelch_write)
      else $error("squelch trim did not take written code");

   property p_guard_keeps;
      soft_rst && reset_retention_guard && !image_load
         |=> $stable(squelch_trip_adjust);
   endproperty
   a_guard_keeps: assert property (p_guard_keeps)
      else $error("guarded squelch trim changed on soft reset");

   property p_image_pick;
      image_load |=> image == ($past(eeprom_present) ? $past(eeprom_image) :
         $past(otp_programmed) ? $past(otp_image) : 6'h00);
   endproperty
   a_image_pick: assert property (p_image_pick)
      else $error("image source priority wrong");

   property p_soft_reload;
      soft_rst && !image_load && !reset_retention_guard
         |=> {squelch_trip_adjust, driver_50ohm_select, strobe_slew_adjust,
         data_strobe_exchange} == $past(image);
   endproperty
   a_soft_reload: assert property (p_soft_reload)
      else $error("soft reset did not restore image");

   property p_strap_mode;
      strap_take |=> interchip_mode_select == $past(strap_sync);
   endproperty
   a_strap_mode: assert property (p_strap_mode)
      else $error("mode default does not follow strap");

   property p_reserved_zero;
      rd_do && (rd_ctrl || rd_ic) |=> (s_axi_rdata & ~($past(rd_ctrl) ?
         (`CTRL_RW_MASK | 32'h18000000) : `IC_RW_MASK)) == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read nonzero");

   property p_sync_delay;
      $past(resetn, 2) |-> afe_sync == $past(afe_status_async, 2);
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("status not passed through two stages");

   property p_set_wins;
      ev_set[0] |=> ev_status[0];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost against clear");

endmodule

// [afe_frontend_model.sv]
// Behavioural model of the analog front end status side
// Assumes the bench requests level changes and end-of-packet strobes
`timescale 1ns/1ns

module afe_frontend_model
   import afe_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic line_invalid_req,
   input wire logic disc_req,
   input wire logic eop_req,
   output afe_status_t afe_status_async,
   output logic hs_eop_bit32
);

   ////////////////////////////////////////////////////////////////////////
   // Status levels move off the clock edge
   always @(line_invalid_req, disc_req) begin
      afe_status_async <= #3 {line_invalid_req, disc_req};
   end

   ////////////////////////////////////////////////////////////////////////
   // One-cycle strobe at the 32nd bit time of an end-of-packet
   always @(posedge mclk) begin
      hs_eop_bit32 <= eop_req;
   end
endmodule

// [test_usb_afe_interchip_config_regs.sv]
// Self-checking bench for the front-end configuration register bank
// Assumes the design files and the front-end model are compiled first
`timescale 1ns/1ns
`include "afe_regs_cfg.svh"

module test_usb_afe_interchip_config_regs
   import afe_regs_pkg::*;
   ;
   localparam cfg_image_t img_ee = 6'h2D;
   localparam cfg_image_t img_otp = 6'h32;
   logic mclk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic eeprom_present, otp_programmed, image_load, usb_bus_reset;
   logic lite_reset, reset_retention_guard, interchip_select_strap;
   logic hs_eop_bit32, line_invalid_req, disc_req, eop_req;
   cfg_image_t eeprom_image, otp_image;
   afe_status_t afe_status_async;
   logic hs_termination_enable, interchip_mode_select, driver_50ohm_select;
   logic strobe_slew_adjust, data_strobe_exchange, irq;
   logic [2:0] squelch_trip_adjust;
   int error_cnt, comparisons;

   ////////////////////////////////////////////////////////////////////////
   // Design and front-end model
   usb_afe_interchip_config_regs DUT (.mclk, .resetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .eeprom_present, .otp_programmed, .eeprom_image, .otp_image,
      .image_load, .usb_bus_reset, .lite_reset, .reset_retention_guard,
      .interchip_select_strap, .afe_status_async, .hs_eop_bit32,
      .hs_termination_enable, .squelch_trip_adjust, .interchip_mode_select,
      .driver_50ohm_select, .strobe_slew_adjust, .data_strobe_exchange,
      .irq);
   afe_frontend_model frontend (.mclk, .line_invalid_req, .disc_req,
      .eop_req, .afe_status_async, .hs_eop_bit32);

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////
   // Checking and closing
   task automatic report_and_stop;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      chk({31'h0, got}, {31'h0, exp}, what);
   endtask

   task automatic chk_cfg(input cfg_image_t e);
      chk({26'h0, squelch_trip_adjust, driver_50ohm_select,
           strobe_slew_adjust, data_strobe_exchange}, {26'h0, e}, "config");
   endtask

   task automatic timeout(input string what);
      error_cnt++;
      $display("wrong value at %0t: no answer to %s", $time, what);
      report_and_stop();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Register bus master
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                            input logic [1:0] er);
      int n;
      logic aw_ok;
      logic w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      repeat (51) begin
         @(posedge mclk);
         n++;
         if (n > 50) timeout("write");
         if (s_axi_bvalid && aw_ok && w_ok) begin
            chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
            break;
         end
         if (s_axi_awready && !aw_ok) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w_ok) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
   endtask

   task automatic axi_read(input logic [11:0] a, input logic [31:0] exp,
                           input logic [1:0] er);
      int n;
      logic ar_ok;
      n = 0;
      ar_ok = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      repeat (51) begin
         @(posedge mclk);
         n++;
         if (n > 50) timeout("read");
         if (s_axi_rvalid && ar_ok) begin
            chk(s_axi_rdata, exp, "read data");
            chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
            break;
         end
         if (s_axi_arready && !ar_ok) begin
            ar_ok = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Side-band stimulus
   task automatic pulse(input int which);
      case (which)
         0: image_load <= 1'b1;
         1: usb_bus_reset <= 1'b1;
         2: lite_reset <= 1'b1;
         default: eop_req <= 1'b1;
      endcase
      @(posedge mclk);
      image_load <= 1'b0;
      usb_bus_reset <= 1'b0;
      lite_reset <= 1'b0;
      eop_req <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic do_reset(input logic strap);
      interchip_select_strap <= strap;
      resetn <= 1'b0;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      repeat (5) @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, eeprom_present, otp_programmed, image_load} = '0;
      {usb_bus_reset, lite_reset, reset_retention_guard} = '0;
      {line_invalid_req, disc_req, eop_req} = '0;
      s_axi_wstrb = 4'hF;
      eeprom_image = img_ee;
      otp_image = img_otp;
      error_cnt = 0;
      comparisons = 0;
      do_reset(1'b1);
      axi_read(`OFS_FRONTEND_CTRL, 32'h0, `RESP_OKAY);
      axi_read(`OFS_INTERCHIP_EN, 32'h01000000, `RESP_OKAY);
      chk1(interchip_mode_select, 1'b1, "strap mode");
      chk_cfg('0);
      axi_write(`OFS_FRONTEND_CTRL, 32'hFFFFFFFF, `RESP_OKAY);
      axi_read(`OFS_FRONTEND_CTRL, 32'h27000000, `RESP_OKAY);
      chk1(hs_termination_enable, 1'b1, "termination on");
      for (int c = 0; c < 8; c++) begin
         axi_write(`OFS_FRONTEND_CTRL, 32'(c) << 24, `RESP_OKAY);
         axi_read(`OFS_FRONTEND_CTRL, 32'(c) << 24, `RESP_OKAY);
         chk({29'h0, squelch_trip_adjust}, 32'(c), "squelch");
         chk1(hs_termination_enable, 1'b0, "termination off");
      end
      axi_write(`OFS_INTERCHIP_EN, 32'hFFFFFFFF, `RESP_OKAY);
      axi_read(`OFS_INTERCHIP_EN, 32'h01070000, `RESP_OKAY);
      chk_cfg(6'h3F);
      axi_write(`OFS_INTERCHIP_EN, 32'h0, `RESP_OKAY);
      chk1(interchip_mode_select, 1'b0, "usb mode");
      axi_write(12'h100, 32'hFFFFFFFF, `RESP_SLVERR);
      axi_read(12'h100, 32'h0, `RESP_SLVERR);
      for (int k = 0; k < 3; k++) begin
         eeprom_present <= (k == 2);
         otp_programmed <= (k >= 1);
         pulse(0);
         chk_cfg(k == 2 ? img_ee : (k == 1 ? img_otp : 6'h00));
      end
      axi_read(`OFS_EVENT_STATUS, 32'h4, `RESP_OKAY);
      chk1(irq, 1'b0, "irq masked");
      axi_write(`OFS_EVENT_MASK, 32'h7, `RESP_OKAY);
      chk1(irq, 1'b1, "irq raised");
      axi_write(`OFS_EVENT_STATUS, 32'h4, `RESP_OKAY);
      chk1(irq, 1'b0, "irq cleared");
      axi_write(`OFS_FRONTEND_CTRL, 32'h02000000, `RESP_OKAY);
      axi_write(`OFS_INTERCHIP_EN, 32'h01020000, `RESP_OKAY);
      pulse(1);
      chk_cfg(img_ee);
      axi_write(`OFS_FRONTEND_CTRL, 32'h02000000, `RESP_OKAY);
      axi_write(`OFS_INTERCHIP_EN, 32'h01020000, `RESP_OKAY);
      reset_retention_guard <= 1'b1;
      pulse(2);
      chk_cfg(6'h15);
      axi_write(`OFS_FRONTEND_CTRL, 32'h0, `RESP_OKAY);
      line_invalid_req <= 1'b1;
      repeat (6) @(posedge mclk);
      axi_read(`OFS_FRONTEND_CTRL, 32'h10000000, `RESP_OKAY);
      chk1(irq, 1'b1, "irq line event");
      axi_write(`OFS_EVENT_STATUS, 32'h2, `RESP_OKAY);
      disc_req <= 1'b1;
      repeat (6) @(posedge mclk);
      axi_read(`OFS_FRONTEND_CTRL, 32'h10000000, `RESP_OKAY);
      pulse(3);
      axi_read(`OFS_FRONTEND_CTRL, 32'h18000000, `RESP_OKAY);
      axi_read(`OFS_EVENT_STATUS, 32'h1, `RESP_OKAY);
      {line_invalid_req, disc_req} <= 2'h0;
      repeat (6) @(posedge mclk);
      axi_read(`OFS_FRONTEND_CTRL, 32'h08000000, `RESP_OKAY);
      pulse(3);
      axi_read(`OFS_FRONTEND_CTRL, 32'h0, `RESP_OKAY);
      axi_write(`OFS_EVENT_MASK, 32'h0, `RESP_OKAY);
      axi_write(`OFS_EVENT_STATUS, 32'h7, `RESP_OKAY);
      line_invalid_req <= 1'b1;
      repeat (6) @(posedge mclk);
      chk1(irq, 1'b0, "irq masked event");
      axi_read(`OFS_EVENT_STATUS, 32'h2, `RESP_OKAY);
      do_reset(1'b0);
      axi_read(`OFS_INTERCHIP_EN, 32'h0, `RESP_OKAY);
      chk1(interchip_mode_select, 1'b0, "strap low mode");
      report_and_stop();
   end
endmodule
